// ===== event_status_consts.svh
// constants for the event status command unit
// assumes inclusion by the design module
`ifndef EVENT_STATUS_CONSTS_SVH
`define EVENT_STATUS_CONSTS_SVH

// event bit positions (weights 128..1)
`define EV_BIT_PON     3'd7
`define EV_BIT_URQ     3'd6
`define EV_BIT_CME     3'd5
`define EV_BIT_EXE     3'd4
`define EV_BIT_DDE     3'd3
`define EV_BIT_QYE     3'd2
`define EV_BIT_NU      3'd1
`define EV_BIT_OPC     3'd0
// bits that exist; weight two never stores
`define EV_USED_MASK   8'hFD
`define EV_RESET_VAL   8'h00
`define EV_ZERO        8'h00
// boolean parameter forms
`define BOOL_TRUE      1'b1
`define BOOL_FALSE     1'b0
// preselected values for special numeric forms
`define NUM_DEFAULT    8'h00
`define NUM_MINIMUM    8'h00
`define NUM_MAXIMUM    8'hFF
// numeric parameter: signed fixed point, four fraction bits,
// worked one bit wider so rounding cannot wrap
`define NUM_FRAC_BITS  4
`define NUM_HALF       17'sh00008
`define NUM_BYTE_MAX   17'sh000FF
`define NUM_ZERO       17'sh00000

`endif

// ===== event_status_pkg.sv
// types for the event status command unit
// assumes event_status_consts.svh is on the include path
`default_nettype none

package event_status_pkg;

	// decoded remote command
	typedef enum logic [3:0] {
		CMD_NONE     = 4'h0,
		CMD_CLEAR    = 4'h1,
		CMD_SET_MASK = 4'h2,
		CMD_ASK_MASK = 4'h3,
		CMD_ASK_STAT = 4'h4,
		CMD_OP_DONE  = 4'h5,
		CMD_RESET    = 4'h6,
		CMD_SET_FLAG = 4'h7
	} command_t;

	// form in which a numeric or boolean parameter arrives
	typedef enum logic [2:0] {
		ARG_NUMBER  = 3'h0,
		ARG_DEFAULT = 3'h1,
		ARG_MINIMUM = 3'h2,
		ARG_MAXIMUM = 3'h3,
		ARG_WORD_ON = 3'h4,
		ARG_WORD_OFF = 3'h5
	} arg_form_t;

	// completion tracking for the operation complete bit
	typedef enum logic [1:0] {
		OPC_IDLE    = 2'b00,
		OPC_WAITING = 2'b01
	} opc_state_t;

endpackage : event_status_pkg

`default_nettype wire

// ===== event_status_command_unit.sv
// event status command unit: clear, mask load/query, status query
// assumes commands arrive as one-cycle strobes from a parser on clk
//
// Operation
// - clear command empties status and queue
// - mask command loads enable register
// - enable one passes bit, zero blocks
// - bit weights PON128..QYE4, two unused, OPC1
// - mask query returns enable contents
// - query answers lie within zero..255
// - status query returns then clears status
// - numeric boolean rounds to nearest integer
// - rounded nonzero boolean means one
// - ON/OFF accepted; booleans report 1/0
// - DEFault picks preselected convenient value
// - MINimum lowest, MAXimum largest accepted value
// - after op-complete command, set OPC when idle
// - device reset leaves event registers alone
`default_nettype none
`include "event_status_consts.svh"

module event_status_command_unit (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       reset,
	// command strobe from parser
	input  wire logic                       cmdValid,
	input  wire event_status_pkg::command_t cmdCode,
	input  wire event_status_pkg::arg_form_t argForm,
	input  wire logic signed [15:0]         argValue,
	// device events, one-cycle pulses, bit per weight
	input  wire logic [7:0]                 eventPulse,
	input  wire logic                       opsPending,
	// response
	output logic                            respValid,
	output logic [7:0]                      respValue,
	output logic                            boolValue,
	// state
	output logic [7:0]                      enableMask,
	output logic [7:0]                      eventStatus,
	output logic                            summaryEvent,
	output logic                            queueClear
);

	// ***********************************************
	// command decode
	// ***********************************************
	wire logic isClear   = cmdValid &&
		(cmdCode == event_status_pkg::CMD_CLEAR);
	wire logic isSetMask = cmdValid &&
		(cmdCode == event_status_pkg::CMD_SET_MASK);
	wire logic isAskMask = cmdValid &&
		(cmdCode == event_status_pkg::CMD_ASK_MASK);
	wire logic isAskStat = cmdValid &&
		(cmdCode == event_status_pkg::CMD_ASK_STAT);
	wire logic isOpDone  = cmdValid &&
		(cmdCode == event_status_pkg::CMD_OP_DONE);
	wire logic isSetFlag = cmdValid &&
		(cmdCode == event_status_pkg::CMD_SET_FLAG);

	// ***********************************************
	// parameter conversion
	// ***********************************************
	// round to nearest: add half, drop fraction
	// one guard bit: the largest inputs must not wrap negative
	wire logic signed [16:0] argWide = 17'(argValue);
	wire logic signed [16:0] roundedSum =
		argWide + `NUM_HALF;
	wire logic signed [16:0] roundedInt =
		roundedSum >>> `NUM_FRAC_BITS;
	wire logic numIsTrue = (roundedInt != `NUM_ZERO);

	// byte value of the numeric forms, clamped to the register range
	wire logic [7:0] numByte =
		(roundedInt < `NUM_ZERO) ? `EV_ZERO :
		(roundedInt > `NUM_BYTE_MAX) ? `NUM_MAXIMUM :
		roundedInt[7:0];

	logic [7:0] argByte;
	logic       argBool;
	always_comb begin
		unique case (argForm)
			event_status_pkg::ARG_DEFAULT: begin
				argByte = `NUM_DEFAULT;
				argBool = `BOOL_FALSE;
			end
			event_status_pkg::ARG_MINIMUM: begin
				argByte = `NUM_MINIMUM;
				argBool = `BOOL_FALSE;
			end
			event_status_pkg::ARG_MAXIMUM: begin
				argByte = `NUM_MAXIMUM;
				argBool = `BOOL_TRUE;
			end
			event_status_pkg::ARG_WORD_ON: begin
				argByte = `NUM_MAXIMUM;
				argBool = `BOOL_TRUE;
			end
			event_status_pkg::ARG_WORD_OFF: begin
				argByte = `EV_ZERO;
				argBool = `BOOL_FALSE;
			end
			default: begin
				argByte = numByte;
				argBool = numIsTrue;
			end
		endcase
	end

	// ***********************************************
	// operation complete tracking
	// ***********************************************
	event_status_pkg::opc_state_t opcState_reg;
	event_status_pkg::opc_state_t opcState_next;
	logic opcFire;

	always_comb begin
		opcState_next = opcState_reg;
		opcFire = 1'b0;
		unique case (opcState_reg)
			event_status_pkg::OPC_IDLE: begin
				if (isOpDone) begin
					opcState_next = event_status_pkg::OPC_WAITING;
				end
			end
			event_status_pkg::OPC_WAITING: begin
				if (!opsPending) begin
					opcFire = 1'b1;
					opcState_next = event_status_pkg::OPC_IDLE;
				end
			end
			default: begin
				opcState_next = event_status_pkg::OPC_IDLE;
			end
		endcase
	end

	// ***********************************************
	// event registers
	// ***********************************************
	logic [7:0] newEvents;
	always_comb begin
		newEvents = eventPulse;
		newEvents[`EV_BIT_OPC] = eventPulse[`EV_BIT_OPC] | opcFire;
	end

	logic [7:0] status_reg;
	logic [7:0] mask_reg;
	// set wins over clear, so a same-cycle event survives the read
	wire logic statClear = isClear || isAskStat;
	localparam logic [7:0] usedBits = `EV_USED_MASK;
	wire logic [7:0] status_next;
	// one latch per event bit; the unused weight never stores
	for (genvar b = 0; b < $bits(status_reg); b++) begin : gen_status_bit
		assign status_next[b] = usedBits[b] &&
			(newEvents[b] || (!statClear && status_reg[b]));
	end
	// device reset command is not decoded here, registers keep value
	wire logic [7:0] mask_next = isSetMask ?
		(argByte & `EV_USED_MASK) : mask_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			status_reg   <= `EV_RESET_VAL;
			mask_reg     <= `EV_RESET_VAL;
			opcState_reg <= event_status_pkg::OPC_IDLE;
		end else begin
			status_reg   <= status_next;
			mask_reg     <= mask_next;
			opcState_reg <= opcState_next;
		end
	end

	// ***********************************************
	// responses
	// ***********************************************
	logic [7:0] respValue_reg;
	logic       respValid_reg;
	logic       bool_reg;
	logic       queueClear_reg;
	// query returns value before this cycle's clear
	wire logic [7:0] respValue_next =
		isAskMask ? mask_reg :
		isAskStat ? status_reg :
		respValue_reg;

	// answer and queue strobes stand for one cycle only
	wire logic respValid_next = isAskMask || isAskStat;
	wire logic queueClear_next = isClear;

	always_ff @(posedge clk) begin
		if (reset) begin
			respValue_reg  <= `EV_ZERO;
			respValid_reg  <= `BOOL_FALSE;
			bool_reg       <= `BOOL_FALSE;
			queueClear_reg <= `BOOL_FALSE;
		end else begin
			respValue_reg  <= respValue_next;
			respValid_reg  <= respValid_next;
			queueClear_reg <= queueClear_next;
			if (isSetFlag) begin
				bool_reg <= argBool;
			end
		end
	end

	assign respValid    = respValid_reg;
	assign respValue    = respValue_reg;
	assign boolValue    = bool_reg;
	assign enableMask   = mask_reg;
	assign eventStatus  = status_reg;
	assign summaryEvent = |(status_reg & mask_reg);
	assign queueClear   = queueClear_reg;

endmodule : event_status_command_unit

`default_nettype wire

// ===== event_status_props.sv
// assertions over the event status command unit ports
// assumes answers one cycle after the command edge
`default_nettype none
module event_status_props (
	// clock and reset
	input wire logic                        clk,
	input wire logic                        reset,
	// command strobe
	input wire logic                        cmdValid,
	input wire event_status_pkg::command_t  cmdCode,
	input wire event_status_pkg::arg_form_t argForm,
	input wire logic signed [15:0]          argValue,
	// device events
	input wire logic [7:0]                  eventPulse,
	input wire logic                        opsPending,
	// response and state
	input wire logic                        respValid,
	input wire logic [7:0]                  respValue,
	input wire logic                        boolValue,
	input wire logic [7:0]                  enableMask,
	input wire logic [7:0]                  eventStatus,
	input wire logic                        summaryEvent,
	input wire logic                        queueClear
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire logic clr = cmdValid && cmdCode == event_status_pkg::CMD_CLEAR;
	wire logic askM = cmdValid && cmdCode == event_status_pkg::CMD_ASK_MASK;
	wire logic askS = cmdValid && cmdCode == event_status_pkg::CMD_ASK_STAT;
	wire logic setMax = cmdValid && argForm == event_status_pkg::ARG_MAXIMUM
		&& cmdCode == event_status_pkg::CMD_SET_MASK;
	// events that can store; op-complete bit may be set by waiting logic
	wire logic [7:0] evIn = eventPulse & 8'hFD;
	a_clear_queue: assert property (clr |=> queueClear)
		else $error("no queue clear");
	a_clear_status: assert property (clr |=>
		(eventStatus | 8'h01) == ($past(evIn) | 8'h01))
		else $error("status not cleared");
	a_mask_max: assert property (setMax |=> enableMask == 8'hFD)
		else $error("mask max wrong");
	a_mask_query: assert property (askM |=>
		respValid && respValue == $past(enableMask))
		else $error("mask answer wrong");
	a_stat_query: assert property (askS |=>
		respValid && respValue == $past(eventStatus)
		&& (eventStatus | 8'h01) == ($past(evIn) | 8'h01))
		else $error("status answer wrong");
	a_resp_cause: assert property (respValid |-> $past(askM || askS))
		else $error("answer without query");
	a_event_latch: assert property (!clr && !askS |=>
		(eventStatus & $past(eventStatus | evIn)) == $past(eventStatus | evIn))
		else $error("event bit lost");
	a_summary_mask: assert property (
		summaryEvent == |(eventStatus & enableMask))
		else $error("summary wrong");
	a_unused_bit: assert property (!enableMask[1] && !eventStatus[1])
		else $error("unused bit set");
	cover property (askS ##1 respValid);
	cover property (clr);
	cover property (summaryEvent);
endmodule : event_status_props
bind event_status_command_unit event_status_props chk_u (
	.clk(clk), .reset(reset),
	.cmdValid(cmdValid), .cmdCode(cmdCode),
	.argForm(argForm), .argValue(argValue),
	.eventPulse(eventPulse), .opsPending(opsPending),
	.respValid(respValid), .respValue(respValue),
	.boolValue(boolValue), .enableMask(enableMask),
	.eventStatus(eventStatus), .summaryEvent(summaryEvent),
	.queueClear(queueClear)
);
`default_nettype wire

// ===== remote_controller.sv
// controller model issuing one-cycle command strobes
// assumes the caller waits on falling edges of clk
`default_nettype none
module remote_controller (
	// clock
	input  wire logic                          clk,
	// command strobe to the unit
	output var  logic                          cmdValid,
	output var  event_status_pkg::command_t    cmdCode,
	output var  event_status_pkg::arg_form_t   argForm,
	output var  logic signed [15:0]            argValue
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmdValid = 1'h0;
		cmdCode = event_status_pkg::CMD_NONE;
		argForm = event_status_pkg::ARG_NUMBER;
		argValue = 16'h0000;
	end
	task send(logic [3:0] c, logic [2:0] f, logic [15:0] v);
		@(negedge clk);
		cmdValid = 1'h1;
		cmdCode = event_status_pkg::command_t'(c);
		argForm = event_status_pkg::arg_form_t'(f);
		argValue = v;
		@(negedge clk);
		cmdValid = 1'h0;
		argValue = ~v;
	endtask : send
endmodule : remote_controller
`default_nettype wire

// ===== tb.sv
// self-checking bench for the event status command unit
// assumes the controller model and bound checker are compiled
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(n, e, g) check(n, 9'(e), 9'(g))
	localparam logic [18:0] TAB [6] = '{19'h00008, 19'h00007, 19'h00020,
		19'h0FFF8, 19'h40000, 19'h50000};
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic opsPending = 1'h0;
	logic [7:0] eventPulse = 8'h00;
	logic cmdValid, respValid, boolValue, summaryEvent, queueClear;
	event_status_pkg::command_t cmdCode;
	event_status_pkg::arg_form_t argForm;
	logic signed [15:0] argValue;
	logic [7:0] respValue, enableMask, eventStatus;
	int n_fail = 0;
	int num_checks = 0;
	remote_controller ctl_u (.*);
	event_status_command_unit dut_u (.*);
	always #5 clk = ~clk;
	task check(string n, logic [8:0] e, logic [8:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s exp %0h got %0h", n, e, g);
		end
	endtask : check
	task ask(logic [3:0] c, logic [7:0] e);
		ctl_u.send(c, 3'h0, 16'h0000);
		`CHK("answer", {1'h1, e}, {respValid, respValue});
	endtask : ask
	task pulse(logic [7:0] v);
		@(negedge clk) eventPulse = v;
		@(negedge clk) eventPulse = 8'h00;
	endtask : pulse
	task t_mask();
		`CHK("mask", 9'h000, enableMask);
		ctl_u.send(4'h2, 3'h0, 16'h0190);
		ask(4'h3, 8'h19);
		ctl_u.send(4'h2, 3'h0, 16'h0198);
		`CHK("mask", 9'h018, enableMask);
		ctl_u.send(4'h2, 3'h3, 16'h0000);
		ask(4'h3, 8'hFD);
		ctl_u.send(4'h2, 3'h2, 16'h0FF0);
		`CHK("mask", 9'h000, enableMask);
		ctl_u.send(4'h2, 3'h0, 16'h0FF0);
		ctl_u.send(4'h2, 3'h1, 16'h0FF0);
		`CHK("mask", 9'h000, enableMask);
		ctl_u.send(4'h2, 3'h0, 16'h0FF0);
		`CHK("mask", 9'h0FD, enableMask);
	endtask : t_mask
	task t_status();
		`CHK("status", 9'h000, eventStatus);
		pulse(8'hFF);
		`CHK("status", 9'h0FD, eventStatus);
		`CHK("summary", 9'h001, summaryEvent);
		ask(4'h4, 8'hFD);
		ask(4'h4, 8'h00);
		ctl_u.send(4'h2, 3'h0, 16'h0000);
		pulse(8'h21);
		`CHK("summary", 9'h000, summaryEvent);
	endtask : t_status
	task t_clear();
		ctl_u.send(4'h6, 3'h0, 16'h0000);
		`CHK("status", 9'h021, eventStatus);
		ctl_u.send(4'h1, 3'h0, 16'h0000);
		`CHK("clear", 9'h100, {queueClear, eventStatus});
	endtask : t_clear
	task t_opc();
		opsPending = 1'h1;
		ctl_u.send(4'h5, 3'h0, 16'h0000);
		repeat (3) @(negedge clk);
		`CHK("opc", 9'h000, eventStatus);
		opsPending = 1'h0;
		repeat (3) @(negedge clk);
		ask(4'h4, 8'h01);
	endtask : t_opc
	task t_bool();
		for (int i = 0; i < 6; i++) begin
			ctl_u.send(4'h7, TAB[i][18:16], TAB[i][15:0]);
			`CHK("bool", {8'h00, !i[0]}, boolValue);
		end
	endtask : t_bool
	task summarize();
		if (n_fail == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (16) @(negedge clk);
		reset = 1'h0;
		t_mask();
		t_status();
		t_clear();
		t_opc();
		t_bool();
		summarize();
	end
	// roughly seventy cycles of tests; generous margin
	initial begin
		#20us;
		n_fail++;
		summarize();
	end
endmodule : tb
`default_nettype wire
